/* File: include/stepper_defines.svh */
`ifndef STEPPER_DEFINES_SVH
`define STEPPER_DEFINES_SVH

// sequencer state encoding: state n is index n-1
`define SEQ_STATE_RESET 3'h0
`define SEQ_STEP_HALF 3'h1
`define SEQ_STEP_FULL 3'h2

// thermal trip point and release hysteresis below it, degrees c
`define TEMP_TRIP 8'ha5
`define TEMP_HYST 8'h0f

// overcurrent disable interval, 200 us at 25 ns
`define DISABLE_TIME_NS 32'd200000
`define CLK_PERIOD_NS 32'd25
`define DISABLE_CYCLES (`DISABLE_TIME_NS / `CLK_PERIOD_NS)
`define DISABLE_CNT_W 16

// interrupt bits
`define IRQ_BIT_OVERCUR 0
`define IRQ_BIT_THERM 1
`define IRQ_W 2

// register addresses
`define REG_STATUS 4'h0
`define REG_IRQ_STATUS 4'h1
`define REG_IRQ_MASK 4'h2
`define REG_TEMP 4'h3

`endif

/* File: include/stepper_pkg.sv */
package stepper_pkg;
    typedef enum logic [1:0] {
        BR_RUN = 2'b01,
        BR_OFF = 2'b10
    } bridge_state_e;
endpackage : stepper_pkg

/* File: design/stepper_phase_sequencer.sv */
// Summary of operation
// RQ1 - state selects phase and enable outputs
// RQ2 - advance only on step clock rising edge
// RQ3 - direction input picks up or down
// RQ4 - half step: move by one, wrap eight
// RQ5 - reset or power-up enters state one
// RQ6 - full step from odd: odd states only
// RQ7 - full step from even: even states only
// RQ8 - controller: reset, one half step, select low
// RQ9 - controller: select low during reset gives two-phase
// RQ10 - overcurrent pulls enable pin low, bridges off
// RQ11 - bridges stay off for disable interval
// RQ12 - thermal trip 165, release 15 lower
// RQ13 - enable low disables bridges, sequencer still runs
// RQ14 - no edge, state and outputs hold
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defines.svh"

module stepper_phase_sequencer (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_step_clk,
    input wire logic i_half_full,
    input wire logic i_rotation_direction,
    input wire logic i_seq_reset,
    input wire logic i_enable_pin,
    input wire logic i_overcurrent_detector,
    input wire logic [7:0] i_temp,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_phase_a,
    output logic o_phase_b,
    output logic o_enable_a,
    output logic o_enable_b,
    output logic o_enable_pin_out,
    output logic o_enable_pin_oe,
    output logic o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [1:0] sync_step;
    logic [1:0] sync_half;
    logic [1:0] sync_dir;
    logic [1:0] sync_rst;
    logic [1:0] sync_en;
    logic [1:0] sync_overcur;
    logic step_prev;
    logic [7:0] temp_s1;
    logic [7:0] temp_s2;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sync_step <= 2'h0;
            sync_half <= 2'h0;
            sync_dir <= 2'h0;
            sync_rst <= 2'h0;
            sync_en <= 2'h0;
            sync_overcur <= 2'h0;
            step_prev <= 1'b0;
            temp_s1 <= 8'h0;
            temp_s2 <= 8'h0;
        end else begin
            sync_step <= {sync_step[0], i_step_clk};
            sync_half <= {sync_half[0], i_half_full};
            sync_dir <= {sync_dir[0], i_rotation_direction};
            sync_rst <= {sync_rst[0], i_seq_reset};
            sync_en <= {sync_en[0], i_enable_pin};
            sync_overcur <= {sync_overcur[0], i_overcurrent_detector};
            step_prev <= sync_step[1];
            temp_s1 <= i_temp;
            temp_s2 <= temp_s1;
        end
    end

    logic step_rise;
    assign step_rise = sync_step[1] && !step_prev; // RQ2

    ////////////////////////////////////////////////////////////////////////
    // phase sequencer
    logic [2:0] seq_state;
    logic [2:0] next_seq_state;
    logic [2:0] step_size;

    always_comb begin
        // half step moves by one; full step moves by two, keeping parity
        step_size = sync_half[1] ? `SEQ_STEP_HALF : `SEQ_STEP_FULL; // RQ4 RQ6 RQ7
        if (sync_dir[1]) begin
            next_seq_state = seq_state + step_size; // RQ3
        end else begin
            next_seq_state = seq_state - step_size; // RQ3
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            seq_state <= `SEQ_STATE_RESET; // RQ5
        end else if (sync_rst[1]) begin
            // select low during reset lands in odd state one
            seq_state <= `SEQ_STATE_RESET; // RQ5 RQ9
        end else if (step_rise) begin
            seq_state <= next_seq_state; // RQ2 RQ13
        end
        // otherwise hold RQ14
    end

    ////////////////////////////////////////////////////////////////////////
    // fault protection
    stepper_pkg::bridge_state_e br_state;
    logic [`DISABLE_CNT_W-1:0] dis_cnt;
    logic therm_off;
    logic overcur_event;
    logic therm_event;

    assign overcur_event = sync_overcur[1] && (br_state == stepper_pkg::BR_RUN);
    assign therm_event = !therm_off && (temp_s2 >= `TEMP_TRIP);

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            br_state <= stepper_pkg::BR_RUN;
            dis_cnt <= '0;
        end else begin
            case (br_state)
                stepper_pkg::BR_RUN: begin
                    if (sync_overcur[1]) begin
                        br_state <= stepper_pkg::BR_OFF; // RQ10
                        dis_cnt <= `DISABLE_CNT_W'(`DISABLE_CYCLES - 1); // RQ11
                    end
                end
                stepper_pkg::BR_OFF: begin
                    if (dis_cnt == '0) begin
                        br_state <= stepper_pkg::BR_RUN; // RQ11
                    end else begin
                        dis_cnt <= dis_cnt - 1'b1; // RQ11
                    end
                end
                default: begin
                    br_state <= stepper_pkg::BR_RUN;
                end
            endcase
        end
    end

    // hysteresis keeps the bridges from chattering near the trip point
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            therm_off <= 1'b0;
        end else if (temp_s2 >= `TEMP_TRIP) begin
            therm_off <= 1'b1; // RQ12
        end else if (temp_s2 <= (`TEMP_TRIP - `TEMP_HYST)) begin
            therm_off <= 1'b0; // RQ12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output decode: phase from state, winding off at its zero crossing
    logic next_phase_a;
    logic next_phase_b;
    logic next_en_a;
    logic next_en_b;
    logic bridges_on;
    logic pull_low;

    assign pull_low = (br_state == stepper_pkg::BR_OFF) || therm_off;
    assign bridges_on = sync_en[1] && !pull_low; // RQ13

    always_comb begin
        next_phase_a = 1'b0;
        next_phase_b = 1'b0;
        next_en_a = 1'b1;
        next_en_b = 1'b1;
        case (seq_state) // RQ1
            3'h0: begin next_phase_a = 1'b1; next_phase_b = 1'b1; end
            3'h1: begin next_phase_b = 1'b1; next_en_a = 1'b0; end
            3'h2: begin next_phase_b = 1'b1; end
            3'h3: begin next_en_b = 1'b0; end
            3'h4: begin end
            3'h5: begin next_en_a = 1'b0; end
            3'h6: begin next_phase_a = 1'b1; end
            3'h7: begin next_phase_a = 1'b1; next_en_b = 1'b0; end
            default: begin end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phase_a <= 1'b1;
            o_phase_b <= 1'b1;
            o_enable_a <= 1'b0;
            o_enable_b <= 1'b0;
            o_enable_pin_out <= 1'b0;
            o_enable_pin_oe <= 1'b0;
        end else begin
            o_phase_a <= next_phase_a; // RQ1
            o_phase_b <= next_phase_b; // RQ1
            o_enable_a <= next_en_a && bridges_on; // RQ13
            o_enable_b <= next_en_b && bridges_on; // RQ13
            o_enable_pin_out <= 1'b0;
            o_enable_pin_oe <= pull_low; // RQ10 RQ12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts and register port
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] irq_mask;
    logic [`IRQ_W-1:0] irq_set;
    logic [`IRQ_W-1:0] irq_clr;

    assign irq_set = {therm_event, overcur_event};
    assign irq_clr = (i_wr && i_addr == `REG_IRQ_STATUS) ? i_wdata[`IRQ_W-1:0] : '0;

    // a new event in the clearing cycle wins over the clear
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_W; gi = gi + 1) begin : g_irq
            always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    irq_status[gi] <= 1'b0;
                end else if (irq_set[gi]) begin
                    irq_status[gi] <= 1'b1;
                end else if (irq_clr[gi]) begin
                    irq_status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            irq_mask <= '0;
        end else if (i_wr && i_addr == `REG_IRQ_MASK) begin
            irq_mask <= i_wdata[`IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq <= 1'b0;
        end else begin
            // follow the next status, so a set meeting a clear keeps the line up
            o_irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= 8'h0;
        end else if (i_rd) begin
            case (i_addr)
                `REG_STATUS: o_rdata <= {2'h0, therm_off, br_state == stepper_pkg::BR_OFF, 1'b0, seq_state};
                `REG_IRQ_STATUS: o_rdata <= {6'h0, irq_status};
                `REG_IRQ_MASK: o_rdata <= {6'h0, irq_mask};
                `REG_TEMP: o_rdata <= temp_s2;
                default: o_rdata <= 8'h0;
            endcase
        end else begin
            o_rdata <= 8'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_step_only_edge: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ2
        (!step_rise && !sync_rst[1]) |=> $stable(seq_state)) else $error("state moved without step");

    a_reset_state_one: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ5
        sync_rst[1] |=> seq_state == `SEQ_STATE_RESET) else $error("reset did not give state one");

    a_half_up_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ4
        (step_rise && !sync_rst[1] && sync_half[1] && sync_dir[1])
        |=> seq_state == $past(seq_state) + `SEQ_STEP_HALF) else $error("half step up wrong");

    a_half_down_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ3
        (step_rise && !sync_rst[1] && sync_half[1] && !sync_dir[1])
        |=> seq_state == $past(seq_state) - `SEQ_STEP_HALF) else $error("half step down wrong");

    a_full_parity: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ6
        (step_rise && !sync_rst[1] && !sync_half[1])
        |=> seq_state[0] == $past(seq_state[0]) && seq_state != $past(seq_state))
        else $error("full step lost parity");

    a_full_down_odd: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ6
        (step_rise && !sync_rst[1] && !sync_half[1] && !seq_state[0] && !sync_dir[1])
        |=> seq_state == $past(seq_state) - `SEQ_STEP_FULL) else $error("normal step down wrong");

    a_full_even_dir: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ7
        (step_rise && !sync_rst[1] && !sync_half[1] && seq_state[0] && sync_dir[1])
        |=> seq_state == $past(seq_state) + `SEQ_STEP_FULL) else $error("wave step wrong");

    a_wave_down_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ7
        (step_rise && !sync_rst[1] && !sync_half[1] && seq_state[0] && !sync_dir[1])
        |=> seq_state == $past(seq_state) - `SEQ_STEP_FULL) else $error("wave step down wrong");

    a_output_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ14
        ($stable(seq_state) && $stable(bridges_on))
        |=> ($stable(o_phase_a) && $stable(o_phase_b) && $stable(o_enable_a) && $stable(o_enable_b)))
        else $error("outputs moved while state held");

    sequence s_overcur_hit;
        br_state == stepper_pkg::BR_RUN && sync_overcur[1];
    endsequence
    a_overcur_pulls_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ10
        s_overcur_hit |=> ##1 (o_enable_pin_oe && !o_enable_a && !o_enable_b))
        else $error("overcurrent no shutdown");

    a_disable_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ11
        s_overcur_hit |=> (br_state == stepper_pkg::BR_OFF) [*8]) else $error("disable ended early");

    // cycles spent off, so the whole interval is checked and not only its start
    logic [`DISABLE_CNT_W-1:0] off_span;
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            off_span <= '0;
        end else if (br_state == stepper_pkg::BR_OFF) begin
            off_span <= off_span + 1'b1;
        end else begin
            off_span <= '0;
        end
    end

    a_disable_span: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ11
        $fell(br_state == stepper_pkg::BR_OFF) |-> off_span == `DISABLE_CNT_W'(`DISABLE_CYCLES))
        else $error("disable interval wrong length");

    a_thermal_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ12
        (temp_s2 >= `TEMP_TRIP) |=> ##1 (o_enable_pin_oe && !o_enable_a)) else $error("thermal no shutdown");

    a_thermal_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ12
        (therm_off && temp_s2 > (`TEMP_TRIP - `TEMP_HYST)) |=> therm_off) else $error("thermal released early");

    a_thermal_release: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ12
        (temp_s2 <= (`TEMP_TRIP - `TEMP_HYST)) |=> !therm_off) else $error("thermal not released");

    a_pin_low_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RQ13
        !sync_en[1] |=> !o_enable_a && !o_enable_b) else $error("bridges on while pin low");

    a_overcur_sets_irq: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        overcur_event |=> irq_status[`IRQ_BIT_OVERCUR]) else $error("overcurrent status not set");

    a_therm_sets_irq: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        therm_event |=> irq_status[`IRQ_BIT_THERM]) else $error("thermal status not set");

    a_irq_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (irq_status[`IRQ_BIT_OVERCUR] && !irq_clr[`IRQ_BIT_OVERCUR]) |=> irq_status[`IRQ_BIT_OVERCUR])
        else $error("status bit lost without clear");

    a_rdata_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_rd |=> o_rdata == 8'h0) else $error("read data outside read cycle");

endmodule : stepper_phase_sequencer
`default_nettype wire

/* File: bench/step_controller.sv */
`timescale 1ns/1ps
`default_nettype none

module step_controller (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic i_slow,
    output logic o_step_clk,
    output logic o_busy
);
    logic [3:0] cnt;
    logic [3:0] half;

    // each level lasts at least two system clocks so the pin synchroniser catches it
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 4'h0;
            half <= 4'h0;
            o_step_clk <= 1'h0;
        end else if (i_req && cnt == 4'h0) begin
            cnt <= i_slow ? 4'hb : 4'h3;
            half <= i_slow ? 4'h6 : 4'h2;
            o_step_clk <= 1'h1;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            if (cnt == half) begin
                o_step_clk <= 1'h0;
            end
        end
    end

    assign o_busy = (cnt != 4'h0);
endmodule : step_controller

`default_nettype wire

/* File: bench/test_stepper_phase_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defines.svh"

module test_stepper_phase_sequencer;
    logic clk = 1'h0, rst_n = 1'h0, step_req = 1'h0, slow = 1'h0, half_full = 1'h1, dir = 1'h1;
    logic seq_reset = 1'h0, overcur = 1'h0, wr = 1'h0, rd_s = 1'h0;
    logic [7:0] temp = 8'h19, wdata = 8'h00;
    logic [3:0] addr = 4'h0;
    logic step_clk, busy, pa_o, pb_o, ea_o, eb_o, pin_out, pin_oe, irq;
    logic [7:0] rdata;
    int miscompares = 0, num_checks = 0, cycles = 0, oe_span = 0;
    localparam logic [7:0] pa_t = 8'hc1, ea_t = 8'hdd, pb_t = 8'h07, eb_t = 8'h77;
    // enable pin has an external pull-up
    wire logic en_pin = (pin_oe && !pin_out) ? 1'h0 : 1'h1;

    step_controller i_step_controller (.i_clk_sys(clk), .i_rst_n(rst_n), .i_req(step_req),
        .i_slow(slow), .o_step_clk(step_clk), .o_busy(busy));
    stepper_phase_sequencer i_stepper_phase_sequencer (.i_clk_sys(clk), .i_rst_n(rst_n),
        .i_step_clk(step_clk), .i_half_full(half_full), .i_rotation_direction(dir),
        .i_seq_reset(seq_reset), .i_enable_pin(en_pin), .i_overcurrent_detector(overcur),
        .i_temp(temp), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd_s),
        .o_rdata(rdata), .o_phase_a(pa_o), .o_phase_b(pb_o), .o_enable_a(ea_o),
        .o_enable_b(eb_o), .o_enable_pin_out(pin_out), .o_enable_pin_oe(pin_oe), .o_irq(irq));

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_of_test

    // sized for roughly twice the expected run
    always @(posedge clk) begin
        cycles++;
        // cycles with the enable pin pulled low, for the disable interval
        if (pin_oe) begin
            oe_span++;
        end
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'h1;
        @(posedge clk);
        rd_s <= 1'h0;
        #1 d = rdata;
    endtask : reg_rd

    task automatic step(input logic up, input logic s);
        int n;
        @(posedge clk);
        dir <= up;
        slow <= s;
        step_req <= 1'h1;
        @(posedge clk);
        step_req <= 1'h0;
        // busy only shows once the model has taken the request
        @(posedge clk);
        for (n = 0; n < 20 && busy; n++) @(posedge clk);
        repeat (5) @(posedge clk);
    endtask : step

    task automatic check_pos(input logic [2:0] idx, input logic on);
        logic [7:0] d;
        reg_rd(4'h0, d);
        chk("state", {5'h00, d[2:0]}, {5'h00, idx});
        chk("bridges", {4'h0, pa_o, ea_o, pb_o, eb_o},
            {4'h0, pa_t[idx], ea_t[idx] & on, pb_t[idx], eb_t[idx] & on});
    endtask : check_pos

    task automatic seq_restart(input logic hf);
        @(posedge clk);
        half_full <= hf;
        seq_reset <= 1'h1;
        repeat (4) @(posedge clk);
        seq_reset <= 1'h0;
        repeat (4) @(posedge clk);
        check_pos(3'h0, 1'h1);
    endtask : seq_restart

    task automatic half_step_walk();
        int i;
        seq_restart(1'h1);
        for (i = 1; i <= 8; i++) begin
            step(1'h1, i[0]);
            check_pos(3'(i), 1'h1);
        end
        for (i = 7; i >= 0; i--) begin
            step(1'h0, 1'h0);
            check_pos(3'(i), 1'h1);
        end
    endtask : half_step_walk

    task automatic normal_drive();
        int i;
        seq_restart(1'h0);
        for (i = 1; i <= 4; i++) begin
            step(1'h1, 1'h0);
            check_pos(3'(2 * i), 1'h1);
        end
        for (i = 3; i >= 0; i--) begin
            step(1'h0, 1'h1);
            check_pos(3'(2 * i), 1'h1);
        end
    endtask : normal_drive

    task automatic wave_drive();
        int i;
        seq_restart(1'h1);
        step(1'h0, 1'h0);
        @(posedge clk);
        half_full <= 1'h0;
        check_pos(3'h7, 1'h1);
        for (i = 1; i <= 4; i++) begin
            step(1'h0, 1'h0);
            check_pos(3'(7 - 2 * i), 1'h1);
        end
        for (i = 1; i <= 4; i++) begin
            step(1'h1, 1'h0);
            check_pos(3'(7 + 2 * i), 1'h1);
        end
        repeat (60) @(posedge clk);
        check_pos(3'h7, 1'h1);
    endtask : wave_drive

    task automatic overcurrent_trip();
        int n;
        int base;
        logic [7:0] d;
        base = oe_span;
        reg_wr(4'h2, 8'h01);
        @(posedge clk);
        overcur <= 1'h1;
        repeat (3) @(posedge clk);
        overcur <= 1'h0;
        repeat (6) @(posedge clk);
        chk("pin_pull_low", {7'h00, pin_oe & ~pin_out}, 8'h01);
        chk("irq_overcur", {7'h00, irq}, 8'h01);
        step(1'h1, 1'h0);
        check_pos(3'h1, 1'h0);
        for (n = 0; n < 8200 && pin_oe; n++) @(posedge clk);
        chk("disable_span", {7'h00, (oe_span - base) == `DISABLE_CYCLES}, 8'h01);
        repeat (6) @(posedge clk);
        check_pos(3'h1, 1'h1);
        reg_wr(4'h1, 8'h01);
        reg_rd(4'h1, d);
        chk("irq_status_clear", d, 8'h00);
        chk("irq_released", {7'h00, irq}, 8'h00);
    endtask : overcurrent_trip

    task automatic thermal_trip();
        logic [7:0] d;
        reg_wr(4'h2, 8'h00);
        temp <= 8'ha5;
        repeat (8) @(posedge clk);
        reg_rd(4'h0, d);
        chk("therm_off", {7'h00, d[5] & pin_oe}, 8'h01);
        chk("irq_masked", {7'h00, irq}, 8'h00);
        temp <= 8'h97;
        repeat (8) @(posedge clk);
        chk("therm_hold", {7'h00, pin_oe}, 8'h01);
        temp <= 8'h96;
        repeat (8) @(posedge clk);
        chk("therm_release", {7'h00, pin_oe}, 8'h00);
        check_pos(3'h1, 1'h1);
        reg_rd(4'h3, d);
        chk("temp_reg", d, 8'h96);
        reg_rd(4'h1, d);
        chk("irq_therm", d, 8'h02);
        reg_wr(4'h1, 8'h02);
        reg_wr(4'h9, 8'hff);
        reg_rd(4'h9, d);
        chk("unmapped", d, 8'h00);
        reg_rd(4'h1, d);
        chk("irq_status_empty", d, 8'h00);
    endtask : thermal_trip

    initial begin
        logic [7:0] d;
        repeat (6) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        check_pos(3'h0, 1'h1);
        reg_rd(4'h2, d);
        chk("mask_reset", d, 8'h00);
        half_step_walk();
        normal_drive();
        wave_drive();
        overcurrent_trip();
        thermal_trip();
        end_of_test();
    end
endmodule : test_stepper_phase_sequencer

`default_nettype wire
